// *** inc/sxa_pkg.sv ***
// ============================================================
// Constants and types shared by the stack and exclusive-access unit.
// Assumes a 32-bit core with sixteen general registers, index 15 being the program counter.
//
// What this block does
// - Push uses stack pointer minus four as its highest address.
// - Pop uses the current stack pointer as its lowest address.
// - Lowest-numbered register goes to the lowest address, highest to highest.
// - After push the stack pointer points at the lowest stored word.
// - After pop the stack pointer points just above the highest loaded word.
// - Pop with program counter branches at completion; bit 0 sets execution state.
// - Loaded program counter bit 0 must be one (not checked; bit 0 is copied to execState_q as loaded); branch is halfword aligned.
// - None of these operations change the condition flags.
// - Exclusive load and store exist for word, byte and halfword.
// - Exclusive store writes status 0 when stored, 1 when not.
// - Success only if no other agent touched the location since the load.
// - Monitor clear makes the next exclusive store fail with status 1.
// - Without offset the base register value is the address.
`default_nettype none
package sxa_pkg;
	// ============================================================
	// Operations, sizes and fixed values.
	typedef enum logic [2:0] {
		OP_PUSH = 3'h0,
		OP_POP  = 3'h1,
		OP_LDX  = 3'h2,
		OP_STX  = 3'h3,
		OP_CLRX = 3'h4
	} sxa_op_t;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} sxa_size_t;
	localparam logic [3:0]  PC_IDX      = 4'hf;
	localparam logic [31:0] WORD_STEP   = 32'h4;
	localparam logic [31:0] STATUS_OK   = 32'h0;
	localparam logic [31:0] STATUS_FAIL = 32'h1;
endpackage
`default_nettype wire

// *** hdl/sxa_monitor.sv ***
// ============================================================
// Local exclusive monitor: one tagged address and size.
// Assumes snoop reports from the shared memory system arrive on the core clock.
`default_nettype none
module sxa_monitor
	import sxa_pkg::*;
(
	input  wire logic      clock,     // Core clock.
	input  wire logic      rstn,      // Asynchronous reset, active low.
	input  wire logic      setMon,    // Exclusive load completed.
	input  wire logic      clrMon,    // Exclusive store attempt or monitor clear.
	input  wire logic [31:0] setAddr, // Address of the exclusive load.
	input  wire sxa_size_t setSize,   // Size of the exclusive load.
	input  wire logic [31:0] chkAddr, // Address of a store being checked.
	input  wire sxa_size_t chkSize,   // Size of a store being checked.
	input  wire logic      snoopValid, // Another agent accessed memory.
	input  wire logic [31:0] snoopAddr, // Word address touched by that agent.
	output logic           hit        // Store may proceed.
);
	logic        valid_q;
	logic [31:0] addr_q;
	sxa_size_t   size_q;

	// ============================================================
	// Tag state. A new load wins over any clear arriving in the same cycle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			valid_q <= 1'b0;
			addr_q  <= 32'h0;
			size_q  <= SZ_WORD;
		end else if (setMon) begin
			valid_q <= 1'b1;
			addr_q  <= setAddr;
			size_q  <= setSize;
		end else if (clrMon) begin
			valid_q <= 1'b0;
		end else if (snoopValid && snoopAddr[31:2] == addr_q[31:2]) begin
			valid_q <= 1'b0; // Word granularity is conservative: neighbours also clear.
		end
	end

	// A mismatched address or size fails rather than behaving unpredictably.
	assign hit = valid_q && addr_q == chkAddr && size_q == chkSize;

	property p_setTags;
		@(posedge clock) disable iff (!rstn)
		setMon |=> valid_q && addr_q == $past(setAddr);
	endproperty
	a_setTags: assert property (p_setTags)
		else $error("Monitor did not record load.");

	property p_snoopKills;
		@(posedge clock) disable iff (!rstn)
		!setMon && snoopValid && valid_q && snoopAddr[31:2] == addr_q[31:2] |=> !hit;
	endproperty
	a_snoopKills: assert property (p_snoopKills)
		else $error("Snooped access left monitor.");
endmodule
`default_nettype wire

// *** hdl/sxa_unit.sv ***
// ============================================================
// Stack-multiple push/pop and exclusive load/store/clear execution unit.
// Assumes a register file read port with one cycle latency and a memory port
// that holds request until a one-cycle acknowledge returns read data.
`default_nettype none
module sxa_unit
	import sxa_pkg::*;
(
	input  wire logic        clock,        // Core clock, 50 MHz.
	input  wire logic        rstn,         // Asynchronous reset, active low.
	input  wire logic        cmdValid,     // Operation offered.
	input  wire sxa_op_t     cmdOp,        // Operation code.
	input  wire logic [15:0] cmdRegList,   // Register list for push and pop.
	input  wire logic [31:0] cmdSp,        // Current stack pointer.
	input  wire logic [31:0] cmdBase,      // Base register value.
	input  wire logic        cmdHasOffset, // Offset present.
	input  wire logic [9:0]  cmdOffset,    // Byte offset, multiple of four.
	input  wire sxa_size_t   cmdSize,      // Exclusive access size.
	input  wire logic [3:0]  cmdDataIdx,   // Data register index.
	input  wire logic [3:0]  cmdStatusIdx, // Status register index.
	output logic             cmdReady_q,   // Idle and able to take an operation.
	output logic [3:0]       regRdIdx_q,   // Register file read index.
	input  wire logic [31:0] regRdData,    // Read data, one cycle after index.
	output logic             memReq_q,     // Memory request, held until ack.
	output logic             memWrite_q,   // Request is a write.
	output logic [31:0]      memAddr_q,    // Byte address.
	output sxa_size_t        memSize_q,    // Access size.
	output logic [31:0]      memWdata_q,   // Write data in low bits.
	input  wire logic        memAck,       // Request done this cycle.
	input  wire logic [31:0] memRdata,     // Read data with ack.
	input  wire logic        snoopValid,   // Other master accessed memory.
	input  wire logic [31:0] snoopAddr,    // Address of that access.
	output logic             regWrEn_q,    // Register write pulse.
	output logic [3:0]       regWrIdx_q,   // Register write index.
	output logic [31:0]      regWrData_q,  // Register write data.
	output logic             spWrEn_q,     // Stack pointer write pulse.
	output logic [31:0]      spWrData_q,   // New stack pointer.
	output logic             branchEn_q,   // Branch pulse.
	output logic [31:0]      branchAddr_q, // Halfword-aligned target.
	output logic             execState_q,  // Execution-state bit.
	output logic             done_q        // Operation finished pulse.
);
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_READ = 2'h1,
		S_MEM  = 2'h2,
		S_DONE = 2'h3
	} sxa_state_t;

	// ============================================================
	// Helpers.
	function automatic logic [4:0] countRegs(input logic [15:0] m);
		logic [4:0] n;
		n = 5'h0;
		for (int i = 0; i < 16; i++) n = n + 5'(m[i]);
		return n;
	endfunction

	function automatic logic [3:0] lowestReg(input logic [15:0] m);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 15; i >= 0; i--) if (m[i]) idx = 4'(i);
		return idx;
	endfunction

	function automatic logic [31:0] fitSize(input logic [31:0] d, input sxa_size_t s);
		logic [31:0] r;
		r = d;
		if (s == SZ_BYTE) r = {24'h0, d[7:0]};
		else if (s == SZ_HALF) r = {16'h0, d[15:0]};
		return r;
	endfunction

	sxa_state_t  state_q;
	sxa_op_t     op_q;
	sxa_size_t   size_q;
	logic [15:0] mask_q;
	logic [31:0] spEnd_q;
	logic [3:0]  dataIdx_q;
	logic [3:0]  statusIdx_q;
	logic        monHit;
	logic        accept;
	logic        ackNow;
	logic [3:0]  curIdx;
	logic [15:0] maskLeft;
	logic [31:0] spanBytes;
	logic [31:0] exclAddr;

	assign accept    = cmdValid && cmdReady_q;
	assign ackNow    = state_q == S_MEM && memAck;
	assign curIdx    = lowestReg(mask_q);
	assign maskLeft  = mask_q & ~(16'h1 << curIdx);
	assign spanBytes = 32'({countRegs(cmdRegList), 2'b00});
	assign exclAddr  = cmdBase + (cmdHasOffset ? 32'(cmdOffset) : 32'h0);

	// The check compares against the live command, so it is valid only while idle.
	sxa_monitor u_monitor (
		.clock      (clock),
		.rstn       (rstn),
		.setMon     (ackNow && op_q == OP_LDX),
		.clrMon     (accept && (cmdOp == OP_STX || cmdOp == OP_CLRX)),
		.setAddr    (memAddr_q),
		.setSize    (size_q),
		.chkAddr    (exclAddr),
		.chkSize    (cmdSize),
		.snoopValid (snoopValid),
		.snoopAddr  (snoopAddr),
		.hit        (monHit)
	);

	// ============================================================
	// Sequencing and memory port. Registers leave in ascending order so
	// the lowest index always meets the lowest address.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q     <= S_IDLE;
			cmdReady_q  <= 1'b1;
			op_q        <= OP_CLRX;
			size_q      <= SZ_WORD;
			mask_q      <= 16'h0;
			spEnd_q     <= 32'h0;
			dataIdx_q   <= 4'h0;
			statusIdx_q <= 4'h0;
			regRdIdx_q  <= 4'h0;
			memReq_q    <= 1'b0;
			memWrite_q  <= 1'b0;
			memAddr_q   <= 32'h0;
			memSize_q   <= SZ_WORD;
			memWdata_q  <= 32'h0;
		end else begin
			unique case (state_q)
				S_IDLE: if (accept) begin
					cmdReady_q  <= 1'b0;
					op_q        <= cmdOp;
					size_q      <= cmdSize;
					mask_q      <= cmdRegList;
					dataIdx_q   <= cmdDataIdx;
					statusIdx_q <= cmdStatusIdx;
					unique case (cmdOp)
						OP_PUSH: begin
							memAddr_q  <= cmdSp - spanBytes;
							spEnd_q    <= cmdSp - spanBytes;
							regRdIdx_q <= lowestReg(cmdRegList);
							state_q    <= S_READ;
						end
						OP_POP: begin
							memAddr_q  <= cmdSp;
							spEnd_q    <= cmdSp + spanBytes;
							memReq_q   <= 1'b1;
							memWrite_q <= 1'b0;
							memSize_q  <= SZ_WORD;
							state_q    <= S_MEM;
						end
						OP_LDX: begin
							memAddr_q  <= exclAddr;
							memReq_q   <= 1'b1;
							memWrite_q <= 1'b0;
							memSize_q  <= cmdSize;
							state_q    <= S_MEM;
						end
						OP_STX: begin
							memAddr_q  <= exclAddr;
							memSize_q  <= cmdSize;
							regRdIdx_q <= cmdDataIdx;
							// A failed check skips memory entirely.
							state_q    <= monHit ? S_READ : S_DONE;
						end
						default: state_q <= S_DONE; // Monitor clear only.
					endcase
				end
				S_READ: begin
					memReq_q   <= 1'b1;
					memWrite_q <= 1'b1;
					memWdata_q <= (op_q == OP_STX) ? fitSize(regRdData, size_q) : regRdData;
					if (op_q == OP_PUSH) memSize_q <= SZ_WORD;
					state_q    <= S_MEM;
				end
				S_MEM: if (memAck) begin
					memReq_q <= 1'b0;
					mask_q   <= maskLeft;
					if ((op_q == OP_PUSH || op_q == OP_POP) && maskLeft != 16'h0) begin
						memAddr_q  <= memAddr_q + WORD_STEP;
						regRdIdx_q <= lowestReg(maskLeft);
						memReq_q   <= op_q == OP_POP;
						state_q    <= (op_q == OP_POP) ? S_MEM : S_READ;
					end else begin
						state_q <= S_DONE;
					end
				end
				S_DONE: begin
					cmdReady_q <= 1'b1;
					state_q    <= S_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// Result pulses. Nothing here reaches the condition flags.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			regWrEn_q   <= 1'b0;
			regWrIdx_q  <= 4'h0;
			regWrData_q <= 32'h0;
			spWrEn_q    <= 1'b0;
			spWrData_q  <= 32'h0;
		end else begin
			regWrEn_q <= 1'b0;
			spWrEn_q  <= 1'b0;
			if (state_q == S_IDLE && accept && cmdOp == OP_STX && !monHit) begin
				regWrEn_q   <= 1'b1;
				regWrIdx_q  <= cmdStatusIdx;
				regWrData_q <= STATUS_FAIL;
			end else if (ackNow) begin
				unique case (op_q)
					OP_POP: begin
						regWrEn_q   <= curIdx != PC_IDX;
						regWrIdx_q  <= curIdx;
						regWrData_q <= memRdata;
					end
					OP_LDX: begin
						regWrEn_q   <= 1'b1;
						regWrIdx_q  <= dataIdx_q;
						regWrData_q <= fitSize(memRdata, size_q);
					end
					OP_STX: begin
						regWrEn_q   <= 1'b1;
						regWrIdx_q  <= statusIdx_q;
						regWrData_q <= STATUS_OK;
					end
					default: regWrEn_q <= 1'b0;
				endcase
			end
			if (ackNow && (op_q == OP_PUSH || op_q == OP_POP) && maskLeft == 16'h0) begin
				spWrEn_q   <= 1'b1;
				spWrData_q <= spEnd_q;
			end
		end
	end

	// ============================================================
	// Branch on a popped program counter, held until the pop completes.
	logic        branchPend_q;
	logic [31:0] branchHold_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			branchPend_q <= 1'b0;
			branchHold_q <= 32'h0;
			branchEn_q   <= 1'b0;
			branchAddr_q <= 32'h0;
			execState_q  <= 1'b1;
			done_q       <= 1'b0;
		end else begin
			branchEn_q <= 1'b0;
			done_q     <= state_q == S_DONE;
			if (ackNow && op_q == OP_POP && curIdx == PC_IDX) begin
				branchPend_q <= 1'b1;
				branchHold_q <= memRdata;
			end
			if (state_q == S_DONE && branchPend_q) begin
				branchPend_q <= 1'b0;
				branchEn_q   <= 1'b1;
				branchAddr_q <= {branchHold_q[31:1], 1'b0};
				execState_q  <= branchHold_q[0];
			end
		end
	end

	// ============================================================
	// Checks.
	// The command as it was taken, kept apart from the datapath so that the
	// stack pointer checks do not merely echo the design's own result.
	logic [31:0] seenSp_q;
	logic [4:0]  seenCnt_q;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			seenSp_q  <= 32'h0;
			seenCnt_q <= 5'h0;
		end else if (accept) begin
			seenSp_q  <= cmdSp;
			seenCnt_q <= countRegs(cmdRegList);
		end
	end

	property p_pushFirstAddr;
		@(posedge clock) disable iff (!rstn)
		accept && cmdOp == OP_PUSH |=> ##1 memReq_q && memAddr_q == $past(cmdSp - spanBytes, 2);
	endproperty
	a_pushFirstAddr: assert property (p_pushFirstAddr)
		else $error("Push start address wrong.");

	property p_popFirstAddr;
		@(posedge clock) disable iff (!rstn)
		accept && cmdOp == OP_POP |=> memReq_q && !memWrite_q && memAddr_q == $past(cmdSp);
	endproperty
	a_popFirstAddr: assert property (p_popFirstAddr)
		else $error("Pop start address wrong.");

	property p_spPush;
		@(posedge clock) disable iff (!rstn)
		spWrEn_q && op_q == OP_PUSH |-> spWrData_q == seenSp_q - 32'({seenCnt_q, 2'b00})
			&& memAddr_q == seenSp_q - WORD_STEP;
	endproperty
	a_spPush: assert property (p_spPush) else $error("Push stack pointer wrong.");

	property p_spPop;
		@(posedge clock) disable iff (!rstn)
		spWrEn_q && op_q == OP_POP |-> spWrData_q == memAddr_q + WORD_STEP
			&& spWrData_q == seenSp_q + 32'({seenCnt_q, 2'b00});
	endproperty
	a_spPop: assert property (p_spPop) else $error("Pop stack pointer wrong.");

	property p_branch;
		@(posedge clock) disable iff (!rstn)
		ackNow && op_q == OP_POP && curIdx == PC_IDX && maskLeft == 16'h0
			|=> ##1 branchEn_q && execState_q == $past(memRdata[0], 2) && !branchAddr_q[0];
	endproperty
	a_branch: assert property (p_branch) else $error("Popped branch wrong.");

	property p_stxFail;
		@(posedge clock) disable iff (!rstn)
		accept && cmdOp == OP_STX && !monHit
			|=> regWrEn_q && regWrData_q == STATUS_FAIL && !memReq_q ##1 !memReq_q;
	endproperty
	a_stxFail: assert property (p_stxFail) else $error("Failed store not reported.");

	property p_stxOk;
		@(posedge clock) disable iff (!rstn)
		ackNow && op_q == OP_STX
			|=> regWrEn_q && regWrData_q == STATUS_OK && regWrIdx_q == statusIdx_q;
	endproperty
	a_stxOk: assert property (p_stxOk) else $error("Store status wrong.");

	property p_ldxNoOffset;
		@(posedge clock) disable iff (!rstn)
		accept && cmdOp == OP_LDX && !cmdHasOffset |=> memAddr_q == $past(cmdBase) && memReq_q;
	endproperty
	a_ldxNoOffset: assert property (p_ldxNoOffset)
		else $error("Base address not used.");
endmodule
`default_nettype wire

// *** dv/sxa_mem_model.sv ***
// ============================================================
// Behavioural model of the shared memory behind the stack and exclusive-access unit.
// Assumes a request held until a one-cycle acknowledge, on the core clock.
`default_nettype none
module sxa_mem_model
	import sxa_pkg::*;
(
	input  wire logic        clock,    // Core clock.
	input  wire logic        rstn,     // Asynchronous reset, active low.
	input  wire logic        memReq,   // Request from the unit.
	input  wire logic        memWrite, // Request is a write.
	input  wire logic [31:0] memAddr,  // Byte address.
	input  wire sxa_size_t   memSize,  // Access size.
	input  wire logic [31:0] memWdata, // Write data in low bits.
	input  wire logic [1:0]  lat,      // Extra wait cycles before acknowledge.
	output logic             memAck,   // One-cycle acknowledge.
	output logic [31:0]      memRdata  // Read data, only meaningful with ack.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [64];
	logic [1:0]  waitCnt;

	// ============================================================
	// Start from a known pattern with bit 0 set, so popped targets are legal.
	initial begin
		for (int i = 0; i < 64; i++) begin
			mem[i] = 32'ha5000001 | (32'(i) << 8);
		end
	end

	// Answer after the programmed wait; read data toggles to its inverse each cycle outside ack,
	// so stale values do not hold steady (they return every second cycle).
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			memAck   <= 1'b0;
			waitCnt  <= 2'h0;
			memRdata <= 32'h0;
		end else if (memReq && !memAck && waitCnt == lat) begin
			memAck   <= 1'b1;
			waitCnt  <= 2'h0;
			memRdata <= mem[memAddr[7:2]];
			if (memWrite) begin
				mem[memAddr[7:2]] <= memWdata & ((memSize == SZ_BYTE) ? 32'hff :
					(memSize == SZ_HALF) ? 32'hffff : 32'hffffffff);
			end
		end else begin
			memAck   <= 1'b0;
			memRdata <= ~memRdata;
			if (memReq && !memAck) begin
				waitCnt <= waitCnt + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/sxa_unit_tb_top.sv ***
// ============================================================
// Self-checking testbench for the stack and exclusive-access unit.
// Assumes the memory model beside it and a register file that returns 0xd000000N for index N.
`default_nettype none
module sxa_unit_tb_top
	import sxa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rstn = 1'b0, cmdValid = 1'b0, cmdHasOffset = 1'b0;
	sxa_op_t cmdOp = OP_CLRX;
	sxa_size_t cmdSize = SZ_WORD, memSize_q;
	logic [15:0] cmdRegList = 16'h0;
	logic [31:0] cmdSp = 32'h0, cmdBase = 32'h0, snoopAddr = 32'h0;
	logic [9:0] cmdOffset = 10'h0;
	logic [3:0] cmdDataIdx = 4'h0, cmdStatusIdx = 4'h1, regRdIdx_q, regWrIdx_q;
	logic snoopValid = 1'b0, cmdReady_q, memReq_q, memWrite_q, memAck, regWrEn_q;
	logic spWrEn_q, branchEn_q, execState_q, done_q;
	logic [31:0] regRdData, memAddr_q, memWdata_q, memRdata, regWrData_q, spWrData_q;
	logic [31:0] branchAddr_q, qa[$], qd[$], qs[$], qri[$], qrd[$], spv, brv;
	logic [1:0] lat = 2'h0;
	int error_cnt = 0, samples_checked = 0, spn, brn;

	always #10 clock = ~clock;
	assign regRdData = {28'hd000000, regRdIdx_q};

	sxa_unit u_sxa_unit (.clock(clock), .rstn(rstn), .cmdValid(cmdValid), .cmdOp(cmdOp),
		.cmdRegList(cmdRegList), .cmdSp(cmdSp), .cmdBase(cmdBase),
		.cmdHasOffset(cmdHasOffset), .cmdOffset(cmdOffset), .cmdSize(cmdSize),
		.cmdDataIdx(cmdDataIdx), .cmdStatusIdx(cmdStatusIdx), .cmdReady_q(cmdReady_q),
		.regRdIdx_q(regRdIdx_q), .regRdData(regRdData), .memReq_q(memReq_q),
		.memWrite_q(memWrite_q), .memAddr_q(memAddr_q), .memSize_q(memSize_q),
		.memWdata_q(memWdata_q), .memAck(memAck), .memRdata(memRdata),
		.snoopValid(snoopValid), .snoopAddr(snoopAddr), .regWrEn_q(regWrEn_q),
		.regWrIdx_q(regWrIdx_q), .regWrData_q(regWrData_q), .spWrEn_q(spWrEn_q),
		.spWrData_q(spWrData_q), .branchEn_q(branchEn_q), .branchAddr_q(branchAddr_q),
		.execState_q(execState_q), .done_q(done_q));

	sxa_mem_model u_sxa_mem_model (.clock(clock), .rstn(rstn), .memReq(memReq_q),
		.memWrite(memWrite_q), .memAddr(memAddr_q), .memSize(memSize_q),
		.memWdata(memWdata_q), .lat(lat), .memAck(memAck), .memRdata(memRdata));

	// ============================================================
	// Record every completed access and register, stack pointer and branch pulse; pulses last one cycle, so one look each.
	always @(negedge clock) begin
		if (rstn && memReq_q && memAck) begin
			qa.push_back(memAddr_q);
			qd.push_back(memWrite_q ? memWdata_q : 32'hffffffff);
			qs.push_back({30'h0, memSize_q});
		end
		if (rstn && regWrEn_q) begin
			qri.push_back({28'h0, regWrIdx_q});
			qrd.push_back(regWrData_q);
		end
		if (rstn && spWrEn_q) begin
			spv = spWrData_q;
			spn++;
		end
		if (rstn && branchEn_q) begin
			brv = branchAddr_q;
			brn++;
		end
	end

	// ============================================================
	// Shared helpers: comparison, size mask, memory pattern and command issue.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] msk(input sxa_size_t s);
		return (s == SZ_BYTE) ? 32'hff : (s == SZ_HALF) ? 32'hffff : 32'hffffffff;
	endfunction

	function automatic logic [31:0] pat(input logic [31:0] a);
		return 32'ha5000001 | {24'h0, 2'h0, a[7:2]} << 8;
	endfunction

	// Offer a command once idle, hold it over the taking edge, then wait for done.
	task automatic run(input sxa_op_t op, input logic [15:0] rl, input logic [31:0] b,
		input logic ho, input logic [9:0] off, input sxa_size_t sz);
		int n;
		qa = {};
		qd = {};
		qs = {};
		qri = {};
		qrd = {};
		spn = 0;
		brn = 0;
		n = 0;
		while (!cmdReady_q && n < 50) begin
			@(negedge clock);
			n++;
		end
		cmdOp = op;
		cmdSize = sz;
		{cmdRegList, cmdSp, cmdBase, cmdHasOffset, cmdOffset} = {rl, b, b, ho, off};
		cmdValid = 1'b1;
		@(negedge clock);
		cmdValid = 1'b0;
		n = 0;
		while (done_q !== 1'b1 && n < 50) begin
			@(negedge clock);
			n++;
		end
		chk({31'h0, done_q}, 32'h1);
		@(negedge clock);
	endtask

	// ============================================================
	// Scenarios.
	task automatic t_push();
		lat = 2'h0;
		run(OP_PUSH, 16'h0026, 32'h80, 1'b0, 10'h0, SZ_WORD);
		chk(32'(qa.size()), 32'h3);
		chk(qa[0], 32'h74);
		chk(qd[0], 32'hd0000001);
		chk(qa[2], 32'h7c);
		chk(qd[2], 32'hd0000005);
		chk(spv, 32'h74);
		chk(32'(brn), 32'h0);
	endtask

	task automatic t_pop();
		lat = 2'h2;
		run(OP_POP, 16'h8009, 32'h40, 1'b0, 10'h0, SZ_WORD);
		chk(qa[0], 32'h40);
		chk(qd[0], 32'hffffffff);
		chk(qa[2], 32'h48);
		chk(32'(qri.size()), 32'h2);
		chk(qri[1], 32'h3);
		chk(qrd[1], pat(32'h44));
		chk(spv, 32'h4c);
		chk(brv, pat(32'h48) & 32'hfffffffe);
		chk(32'(brn), 32'h1);
		chk({31'h0, execState_q}, 32'h1);
	endtask

	task automatic t_excl(input sxa_size_t sz, input logic ho);
		logic [31:0] a;
		a = ho ? 32'h28 : 32'h30 + {30'h0, sz} * 4;
		cmdDataIdx = 4'h4;
		cmdStatusIdx = 4'h7;
		lat = 2'h1;
		run(OP_LDX, 16'h0, ho ? 32'h20 : a, ho, 10'h8, sz);
		chk(qa[0], a);
		chk(qs[0], {30'h0, sz});
		chk(qrd[0], pat(a) & msk(sz));
		run(OP_STX, 16'h0, ho ? 32'h20 : a, ho, 10'h8, sz);
		chk(qa[0], a);
		chk(qs[0], {30'h0, sz});
		chk(qd[0], 32'hd0000004 & msk(sz));
		chk(qri[0], 32'h7);
		chk(qrd[0], STATUS_OK);
	endtask

	// A store after clear, after a foreign access, or a second store must all fail.
	task automatic t_fail(input int how);
		cmdStatusIdx = 4'h9;
		run(OP_LDX, 16'h0, 32'h50, 1'b0, 10'h0, SZ_WORD);
		if (how == 0) begin
			run(OP_CLRX, 16'h0, 32'h50, 1'b0, 10'h0, SZ_WORD);
			chk(32'(qa.size() + qri.size()), 32'h0);
		end else if (how == 1) begin
			{snoopValid, snoopAddr} = {1'b1, 32'h52};
			@(negedge clock);
			snoopValid = 1'b0;
		end else begin
			run(OP_STX, 16'h0, 32'h50, 1'b0, 10'h0, SZ_WORD);
			chk(qrd[0], STATUS_OK);
		end
		run(OP_STX, 16'h0, 32'h50, 1'b0, 10'h0, SZ_WORD);
		chk(32'(qa.size()), 32'h0);
		chk(qri[0], 32'h9);
		chk(qrd[0], STATUS_FAIL);
	endtask

	task automatic finish_test();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ============================================================
	// Main sequence: reset for six cycles, then every scenario in turn.
	initial begin
		repeat (6) @(negedge clock);
		rstn = 1'b1;
		chk({31'h0, execState_q}, 32'h1);
		t_pop();
		t_push();
		t_excl(SZ_WORD, 1'b1);
		t_excl(SZ_BYTE, 1'b0);
		t_excl(SZ_HALF, 1'b0);
		t_fail(0);
		t_fail(1);
		t_fail(2);
		finish_test();
	end

	// A hung handshake would stall the run; the scenarios need well under 2000 cycles.
	initial begin
		#40000;
		error_cnt++;
		finish_test();
	end
endmodule
`default_nettype wire
